// file: core/clock_synth_defines.svh
// Constants of the two-wire register port of the clock synthesizer.
// Assumes inclusion by bare name from core design files.
`ifndef CLOCK_SYNTH_DEFINES_SVH
`define CLOCK_SYNTH_DEFINES_SVH

// Bus target address, seven bits
`define BUS_TARGET_ADDRESS     7'h69
// APB byte offsets of the register window
`define OFF_CFG_WINDOW_ADDR    8'h00
`define OFF_CFG_WINDOW_DATA    8'h04
`define OFF_PORT_STATUS        8'h08
`define OFF_OUTPUT_CTRL        8'h0c
`define OFF_DRIVE_CTRL         8'h10
`define OFF_PIN_FUNCTION       8'h14
// Reset defaults
`define RST_OUTPUT_ENABLES     8'hff
`define RST_DRIVE_STRENGTH     16'h0000
`define RST_PIN_FUNCTION       2'b00
// Register array reset value
`define RST_CFG_BYTE           8'h00
// Field positions in the port status register
`define STAT_BUSY_BIT          0
`define STAT_READING_BIT       1
`define STAT_PTR_LSB           8
// Bus rate limit, kbit per second
`define MAX_BUS_RATE_KBPS      400

`endif

// file: core/clock_synth_i2c_register_port.sv
// Two-wire target port of a clock synthesizer with a 256-byte register space.
// Assumes pclk much faster than scl; scl and sda are raw pins; APB reaches the space.
//
// Behaviour
// - Answer only target address 69H.
// - Acknowledge each written byte on ninth clock.
// - Further write bytes go to next location.
// - Pointer holds last accessed location plus one.
// - Read: acknowledge, then send byte at pointer.
// - Read ends on no-ack, release data.
// - Repeated START keeps pointer, stores nothing.
// - Controller ack advances pointer, sends next.
// - Pointer wraps FFH to 00H.
// - Sample SDA at SCL high, change low.
// - START/STOP detected on SDA while SCL high.
// - Registers take defaults at reset.
// - Per-output enable control bits.
// - Four-level drive strength per output.
// - Two multi-function pins select their role.
`include "clock_synth_defines.svh"
`default_nettype none
module clock_synth_i2c_register_port #(
  parameter int NUM_OUTPUTS = 8
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         scl_in,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe,
  output logic      [NUM_OUTPUTS-1:0]       output_enable,
  output clock_synth_pkg::drive_level_e     drive_level [NUM_OUTPUTS],
  output logic                              clock_or_freq_select_pin_is_input,
  output logic                              clock_or_spread_toggle_pin_is_input
);
  import clock_synth_pkg::*;

  // Drive field packs two bits per output into 16 bits
  if (NUM_OUTPUTS < 1 || NUM_OUTPUTS > 8) begin : gen_outputs_check
    $error("NUM_OUTPUTS must be 1 to 8");
  end

  logic [7:0]        cfg_mem [256];
  logic [7:0]        register_pointer_byte;
  logic [7:0]        apb_window_addr;
  logic [NUM_OUTPUTS-1:0] out_en;
  logic [15:0]       drive_bits;
  logic [1:0]        pin_function;
  port_state_e       state;
  logic [2:0]        bit_cnt;
  logic [7:0]        shift_reg;
  logic              is_read;
  logic              scl_meta, scl_sync, scl_prev;
  logic              sda_meta, sda_sync, sda_prev;
  logic              scl_rise, scl_fall, start_seen, stop_seen;
  logic              bus_wr_en;
  logic              apb_wr_en;
  logic              apb_access;
  logic              rd_first_bit;
  logic              win_addr_wr_en;
  logic              out_en_wr_en;
  logic              drive_wr_en;
  logic              pin_fn_wr_en;

  // Two-flop synchronisers on both pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  // Edges compare second and third stage
  assign scl_rise   = scl_sync & ~scl_prev;
  assign scl_fall   = ~scl_sync & scl_prev;
  assign start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_seen  = scl_sync & scl_prev & ~sda_prev & sda_sync;

  // Byte store happens on the rising edge that samples the eighth data bit
  assign bus_wr_en  = (state == ST_WDATA) && scl_rise && (bit_cnt == 3'd7);
  assign apb_access = psel & penable;
  assign apb_wr_en  = apb_access & pwrite & (paddr == `OFF_CFG_WINDOW_DATA);
  // One write strobe per control register
  assign win_addr_wr_en = apb_access & pwrite & (paddr == `OFF_CFG_WINDOW_ADDR);
  assign out_en_wr_en   = apb_access & pwrite & (paddr == `OFF_OUTPUT_CTRL);
  assign drive_wr_en    = apb_access & pwrite & (paddr == `OFF_DRIVE_CTRL);
  assign pin_fn_wr_en   = apb_access & pwrite & (paddr == `OFF_PIN_FUNCTION);
  // First read bit must be on SDA before the next rise
  assign rd_first_bit = cfg_mem[register_pointer_byte][7];

  // Bit-level state machine; sample on rise, drive after fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      bit_cnt   <= 3'd0;
      shift_reg <= 8'h00;
      is_read   <= 1'b0;
    end else if (start_seen) begin
      // repeated start drops a pending write, pointer kept
      state   <= ST_ADDR;
      bit_cnt <= 3'd0;
    end else if (stop_seen) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          bit_cnt <= 3'd0;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_sync};
            bit_cnt   <= bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
              if (state == ST_ADDR) begin
                if (shift_reg[6:0] == `BUS_TARGET_ADDRESS) begin
                  state   <= ST_ADDR_ACK;
                  is_read <= sda_sync;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                state <= ST_WACK;
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall && sda_oe) begin
            if (is_read) begin
              state     <= ST_RDATA;
              shift_reg <= cfg_mem[register_pointer_byte];
            end else begin
              state <= ST_PTR;
            end
            bit_cnt <= 3'd0;
          end
        end
        ST_WACK: begin
          if (scl_fall && sda_oe) begin
            state   <= ST_WDATA;
            bit_cnt <= 3'd0;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            bit_cnt <= bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
              state <= ST_RACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (!sda_sync) begin
              shift_reg <= cfg_mem[register_pointer_byte];
              bit_cnt   <= 3'd0;
            end else begin
              state <= ST_IDLE;
            end
          end else if (scl_fall) begin
            state <= ST_RDATA;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // acknowledge on ninth clock, drive read data bits; otherwise released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_oe <= 1'b0;
    end else if (start_seen || stop_seen) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      case (state)
        ST_ADDR_ACK: begin
          // read MSB follows the address ack at once
          if (sda_oe && is_read) begin
            sda_oe <= ~rd_first_bit;
          end else begin
            sda_oe <= ~sda_oe;
          end
        end
        ST_WACK: begin
          sda_oe <= ~sda_oe;
        end
        ST_RDATA: begin
          sda_oe <= (bit_cnt == 3'd7) ? 1'b0 : ~shift_reg[6];
        end
        ST_RACK: begin
          sda_oe <= ~shift_reg[7];
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end else if (state == ST_RACK && scl_rise && !sda_sync) begin
      sda_oe <= 1'b0;
    end else if (state == ST_ADDR_ACK && sda_oe == 1'b0 && scl_prev && !scl_sync) begin
      sda_oe <= 1'b1;
    end
  end

  // Open-drain: only ever pulls low
  assign sda_out = 1'b0;

  // Pointer handling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      register_pointer_byte <= 8'h00;
    end else if (state == ST_PTR && scl_rise && bit_cnt == 3'd7) begin
      register_pointer_byte <= {shift_reg[6:0], sda_sync};
    end else if (bus_wr_en) begin
      register_pointer_byte <= register_pointer_byte + 8'd1;
    end else if (state == ST_ADDR_ACK && is_read && scl_fall && sda_oe) begin
      // read also leaves pointer one past
      register_pointer_byte <= register_pointer_byte + 8'd1;
    end else if (state == ST_RACK && scl_rise && !sda_sync) begin
      // next byte of a sequential read
      register_pointer_byte <= register_pointer_byte + 8'd1;
    end
  end

  // register space loads defaults at reset
  // Bus store wins a same-cycle APB window write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 256; i++) begin
        cfg_mem[i] <= `RST_CFG_BYTE;
      end
    end else if (bus_wr_en) begin
      cfg_mem[register_pointer_byte] <= {shift_reg[6:0], sda_sync};
    end else if (apb_wr_en) begin
      cfg_mem[apb_window_addr] <= pwdata[7:0];
    end
  end

  // APB window address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_window_addr <= 8'h00;
    end else if (win_addr_wr_en) begin
      apb_window_addr <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_en <= NUM_OUTPUTS'(`RST_OUTPUT_ENABLES);
    end else if (out_en_wr_en) begin
      out_en <= pwdata[NUM_OUTPUTS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_bits <= `RST_DRIVE_STRENGTH;
    end else if (drive_wr_en) begin
      drive_bits <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_function <= `RST_PIN_FUNCTION;
    end else if (pin_fn_wr_en) begin
      pin_function <= pwdata[1:0];
    end
  end

  // Zero wait states; unmapped offsets flag an error
  assign pready  = 1'b1;
  assign pslverr = apb_access && !(paddr inside {`OFF_CFG_WINDOW_ADDR, `OFF_CFG_WINDOW_DATA,
                   `OFF_PORT_STATUS, `OFF_OUTPUT_CTRL, `OFF_DRIVE_CTRL, `OFF_PIN_FUNCTION});

  // Read data straight from state, valid during access
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      `OFF_CFG_WINDOW_ADDR: prdata[7:0] = apb_window_addr;
      `OFF_CFG_WINDOW_DATA: prdata[7:0] = cfg_mem[apb_window_addr];
      `OFF_PORT_STATUS: begin
        prdata[`STAT_BUSY_BIT]          = (state != ST_IDLE);
        prdata[`STAT_READING_BIT]       = is_read;
        prdata[`STAT_PTR_LSB +: 8]      = register_pointer_byte;
      end
      `OFF_OUTPUT_CTRL:     prdata[NUM_OUTPUTS-1:0] = out_en;
      `OFF_DRIVE_CTRL:      prdata[15:0] = drive_bits;
      `OFF_PIN_FUNCTION:    prdata[1:0] = pin_function;
      default:              prdata = 32'h0000_0000;
    endcase
  end

  assign output_enable                       = out_en;
  assign clock_or_freq_select_pin_is_input   = pin_function[0];
  assign clock_or_spread_toggle_pin_is_input = pin_function[1];

  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : gen_drive
      assign drive_level[g] = drive_level_e'(drive_bits[2*g +: 2]);
    end
  endgenerate
endmodule
`default_nettype wire

// file: core/clock_synth_pkg.sv
// Types shared by the two-wire register port.
// Assumes nothing of its surroundings.
`default_nettype none
package clock_synth_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_WDATA,
    ST_WACK,
    ST_RDATA,
    ST_RACK
  } port_state_e;
  typedef enum logic [1:0] {
    DRIVE_LOW,
    DRIVE_MID_LOW,
    DRIVE_MID_HIGH,
    DRIVE_HIGH
  } drive_level_e;
endpackage
`default_nettype wire

// file: testbench/bus_host_model.sv
// Two-wire bus controller model: 160 ns bits, MSB first.
// Assumes SDA is the wired AND of all pulls with a pull-up.
`default_nettype none
module bus_host_model (
  output logic      scl,
  output logic      sda_pull_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_pull_low = 1'b0;
  end
  task automatic bitx(input logic b, output logic r);
    #20 sda_pull_low <= !b;
    #60 scl <= 1'b1;
    #40 r = sda;
    #40 scl <= 1'b0;
  endtask
  task automatic start();
    #20 sda_pull_low <= 1'b0;
    #60 scl <= 1'b1;
    #80 sda_pull_low <= 1'b1;
    #80 scl <= 1'b0;
  endtask
  task automatic stop();
    #20 sda_pull_low <= 1'b1;
    #60 scl <= 1'b1;
    #80 sda_pull_low <= 1'b0;
    #160;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ack_in, ack);
  endtask
endmodule
`default_nettype wire

// file: testbench/port_monitor.sv
// Pin and register checks for the two-wire register port.
// Assumes it is bound to the port top; SDA is pulled up outside.
`default_nettype none
module port_monitor #(parameter int NUM_OUTPUTS = 8) (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [7:0]                   paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         scl_in,
  input wire logic                         sda_in,
  input wire logic                         sda_oe,
  input wire logic [NUM_OUTPUTS-1:0]       output_enable,
  input wire clock_synth_pkg::drive_level_e drive_level [NUM_OUTPUTS],
  input wire logic                         clock_or_freq_select_pin_is_input,
  input wire logic                         clock_or_spread_toggle_pin_is_input
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_wr(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  sequence bus_stop;
    scl_in && $rose(sda_in);
  endsequence
  a_reset_defaults: assert property ($rose(presetn) |-> output_enable == '1 && drive_level[0] == 2'b00
    && !clock_or_freq_select_pin_is_input) else $error("defaults wrong");
  a_oe_change_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved in high");
  a_ack_after_fall: assert property ($rose(sda_oe) |-> !$past(scl_in, 2)) else $error("ack early");
  a_ack_holds_high: assert property ($rose(scl_in) && sda_oe |-> sda_oe [*4]) else $error("ack short");
  a_stop_release: assert property (bus_stop |-> !sda_oe [*8]) else $error("sda held");
  a_enable_write: assert property (apb_wr(8'h0c) |=> output_enable == $past(pwdata[NUM_OUTPUTS-1:0]))
    else $error("enables");
  a_drive_write: assert property (apb_wr(8'h10) |=> drive_level[1] == $past(pwdata[3:2]))
    else $error("drive");
  a_role_write: assert property (apb_wr(8'h14) |=> clock_or_spread_toggle_pin_is_input == $past(pwdata[1]))
    else $error("pin role");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h14 |-> pslverr && pready) else $error("no err");
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Top bench: APB master tasks, host model, port under test.
// Assumes the monitor and host model compile first.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        sda_out, sda_oe, pin_fs, pin_ss, scl, pull;
  logic [7:0]  paddr, oe_bits;
  logic [31:0] pwdata, prdata;
  clock_synth_pkg::drive_level_e lvl [8];
  wire logic   sda = !(pull || (sda_oe && !sda_out));
  int          failures = 0;
  int          tests_run = 0;
  clock_synth_i2c_register_port #(.NUM_OUTPUTS(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .output_enable(oe_bits),
    .drive_level(lvl), .clock_or_freq_select_pin_is_input(pin_fs), .clock_or_spread_toggle_pin_is_input(pin_ss));
  bus_host_model host_u (.scl(scl), .sda_pull_low(pull), .sda(sda));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q & m, exp);
  endtask
  task automatic cfg(input logic [7:0] a, input logic [7:0] exp);
    wr(8'h00, {24'h0, a});
    rd(8'h04, {24'h0, exp}, 32'h0000_00ff);
  endtask
  task automatic sb(input logic [7:0] d, input logic ai, input logic [7:0] eq, input logic ea);
    logic [7:0] q;
    logic ack;
    host_u.xfer(d, ai, q, ack);
    chk({23'h0, ack, q}, {23'h0, ea, eq});
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd(8'h0c, 32'h0000_00ff, 32'hffff_ffff);
    rd(8'h14, 32'h0000_0000, 32'hffff_ffff);
    cfg(8'h37, 8'h00);
    wr(8'h0c, 32'h0000_00a5);
    rd(8'h0c, 32'h0000_00a5, 32'hffff_ffff);
    chk({24'h0, oe_bits}, 32'h0000_00a5);
    wr(8'h10, 32'h0000_e41b);
    chk({30'h0, lvl[1]}, 32'h0000_0002);
    wr(8'h14, 32'h0000_0003);
    chk({30'h0, pin_ss, pin_fs}, 32'h0000_0003);
    apb(1'b0, 8'h18, 32'h0000_0000, q, e);
    chk({31'h0, e}, 32'h0000_0001);
  endtask
  task automatic t_write();
    host_u.start();
    sb(8'hd2, 1'b1, 8'hd2, 1'b0);
    sb(8'hfe, 1'b1, 8'hfe, 1'b0);
    sb(8'ha1, 1'b1, 8'ha1, 1'b0);
    sb(8'hb2, 1'b1, 8'hb2, 1'b0);
    sb(8'hc3, 1'b1, 8'hc3, 1'b0);
    host_u.stop();
    rd(8'h08, 32'h0000_0100, 32'h0000_ff00);
    cfg(8'hfe, 8'ha1);
    cfg(8'h00, 8'hc3);
  endtask
  task automatic t_read();
    wr(8'h00, 32'h0000_0001);
    wr(8'h04, 32'h0000_005a);
    host_u.start();
    sb(8'hd3, 1'b1, 8'hd3, 1'b0);
    sb(8'hff, 1'b1, 8'h5a, 1'b1);
    host_u.stop();
    chk({31'h0, sda_oe}, 32'h0000_0000);
    host_u.start();
    sb(8'hd2, 1'b1, 8'hd2, 1'b0);
    sb(8'hff, 1'b1, 8'hff, 1'b0);
    host_u.start();
    sb(8'hd3, 1'b1, 8'hd3, 1'b0);
    sb(8'hff, 1'b0, 8'hb2, 1'b0);
    sb(8'hff, 1'b0, 8'hc3, 1'b0);
    sb(8'hff, 1'b1, 8'h5a, 1'b1);
    host_u.stop();
    cfg(8'hff, 8'hb2);
  endtask
  task automatic t_foreign();
    host_u.start();
    sb(8'hd4, 1'b1, 8'hd4, 1'b1);
    sb(8'h10, 1'b1, 8'h10, 1'b1);
    sb(8'h77, 1'b1, 8'h77, 1'b1);
    host_u.stop();
    rd(8'h08, 32'h0000_0200, 32'h0000_ff00);
    cfg(8'h10, 8'h00);
  endtask
  task automatic results();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_write();
    t_read();
    t_foreign();
    results();
  end
  initial begin
    #500_000;
    failures++;
    results();
  end
endmodule
bind clock_synth_i2c_register_port port_monitor #(.NUM_OUTPUTS(NUM_OUTPUTS)) mon_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe), .output_enable(output_enable),
  .drive_level(drive_level), .clock_or_freq_select_pin_is_input(clock_or_freq_select_pin_is_input),
  .clock_or_spread_toggle_pin_is_input(clock_or_spread_toggle_pin_is_input));
`default_nettype wire
